// File: design/sensor_cfg.svh
`ifndef SENSOR_CFG_SVH
`define SENSOR_CFG_SVH

// =====================================================================
// widths
`define DATA_W 12
`define CMD_W 16
`define FRAC_W 7
`define FILT_W 3
`define TRIM_W 6
`define OTP_W 9
`define CNT_W 6
`define PAD_W 4

// =====================================================================
// write command layout, first bit received lands in the top
`define CMD_MARK 2'b10
`define MARK_LSB 14
`define A_LSB 11
`define B_LSB 5
`define PAD_LSB 1
`define PROG_BIT 0

// =====================================================================
// non-volatile field layout
`define OTP_A_LSB 6
`define OTP_B_LSB 0

// =====================================================================
// gain trim arithmetic
`define MID_SCALE 12'h800
`define TRIM_MID 7'sh20
`define TRIM_SHIFT 7
`define FULL_SCALE 12'hfff

`endif

// File: design/sensor_pkg.sv
package sensor_pkg;

  // =====================================================================
  // link sequencing
  typedef enum logic [1:0] {
    st_reload,
    st_idle,
    st_sel
  } link_state_e;

endpackage : sensor_pkg

// File: design/core_if.sv
`timescale 1ns/10ps
`include "sensor_cfg.svh"

interface core_if;
  logic [`DATA_W-1:0] sample;
  logic sample_valid;
  logic [`FILT_W-1:0] code;
  logic [`DATA_W-1:0] result;
  logic prog;
  logic [`OTP_W-1:0] prog_bits;
  logic [`OTP_W-1:0] otp_bits;

  modport ctl (
    output sample, sample_valid, code, prog, prog_bits,
    input result, otp_bits
  );
  modport flt (input sample, sample_valid, code, output result);
  modport mem (input prog, prog_bits, output otp_bits);
endinterface : core_if

// File: design/ewma_filter.sv
`timescale 1ns/10ps
`include "sensor_cfg.svh"

module ewma_filter #(
  parameter int DATA_W = `DATA_W,
  parameter int FRAC_W = `FRAC_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // samples in, filtered word out
  core_if.flt f
);
  localparam int ACC_W = DATA_W + FRAC_W;

  // fraction bits must cover the smallest weight
  if (FRAC_W < (1 << `FILT_W) - 1 || DATA_W != `DATA_W) begin : g_bad
    $error("ewma_filter: unsupported width");
  end

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic signed [ACC_W:0] diff;
  logic signed [ACC_W:0] step;

  // =====================================================================
  // acc += (x - acc) * 2^-code, i.e. w*x + (1-w)*prev
  always_comb begin
    diff = $signed({1'b0, f.sample, {FRAC_W{1'b0}}}) - $signed({1'b0, acc});
    step = diff >>> f.code;
    next_acc = acc;
    // one update per sample, no decimation
    if (f.sample_valid) begin
      next_acc = acc + step[ACC_W-1:0];
    end
  end

  // code changes never touch the accumulator
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // fraction kept so slow weights still creep to the final value
  assign f.result = acc[ACC_W-1:FRAC_W];
endmodule : ewma_filter

// File: design/otp_store.sv
`timescale 1ns/10ps
`include "sensor_cfg.svh"

module otp_store (
  // clock
  input wire logic clk,
  // factory blank, models an unprogrammed die
  input wire logic otp_blank,
  // program request and stored fields
  core_if.mem m
);
  logic [`OTP_W-1:0] bits;
  logic [`OTP_W-1:0] next_bits;

  // =====================================================================
  // fuses only go to one while otp_blank is low; zeros sent leave a field open
  always_comb begin
    next_bits = bits;
    if (otp_blank) begin
      next_bits = '0;
    end else if (m.prog) begin
      next_bits = bits | m.prog_bits;
    end
  end

  // no rst_n: content survives every power up reset
  always_ff @(posedge clk) begin
    bits <= next_bits;
  end

  assign m.otp_bits = bits;
endmodule : otp_store

// File: design/hall_sensor_serial_filter_otp.sv
`timescale 1ns/10ps
`include "sensor_cfg.svh"

// =====================================================================
// Behaviour
// - serial input low: shift out 12-bit result
// - filter output is w*sample plus (1-w)*previous
// - filter keeps timing, one output per sample
// - power up clears filter previous value
// - new filter setting keeps accumulated state
// - filter code halves weight per step
// - trim steps about 0.8 percent, 25 span
// - trim zero lowest sensitivity, ones highest
// - program bit set commits fields to fuses
// - programmed fuse bits never return to zero while otp_blank is low
// - programming strobe at next chip select fall
// - program bit clear gives preview only
// - zero field stays unprogrammed and adjustable
// - frame: 10, filter, trim, 0000, program
// - daisy chain with 32 clock frames
// - sample on rising, shift on falling
// - output driven only while selected
// - result loaded at chip select falling edge
// - reset clears state, then reloads fuses

module hall_sensor_serial_filter_otp (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // converter results
  input wire logic [`DATA_W-1:0] adc_data,
  input wire logic adc_valid,
  // non-volatile store blanking
  input wire logic otp_blank,
  // status
  output logic [`FILT_W-1:0] filter_code,
  output logic [`TRIM_W-1:0] trim_code,
  output logic otp_prog_strobe,
  output logic [`OTP_W-1:0] otp_fields
);

  core_if bus ();

  // =====================================================================
  // pin synchronisers
  logic cs_s1;
  logic cs_s2;
  logic cs_q;
  logic sck_s1;
  logic sck_s2;
  logic sck_q;
  logic sdi_s1;
  logic sdi_s2;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_q <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_q <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_q <= cs_s2;
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_q <= sck_s2;
      sdi_s1 <= sdi;
      sdi_s2 <= sdi_s1;
    end
  end

  assign cs_fall = cs_q & ~cs_s2;
  assign cs_rise = ~cs_q & cs_s2;
  assign sck_rise = ~sck_q & sck_s2;
  assign sck_fall = sck_q & ~sck_s2;

  // =====================================================================
  // command decode
  function automatic logic is_write(
    input logic [`CMD_W-1:0] cmd,
    input logic [`CNT_W-1:0] cnt
  );
    is_write = (cnt >= `CNT_W'(`CMD_W)) &&
               (cmd[`MARK_LSB +: 2] == `CMD_MARK) &&
               (cmd[`PAD_LSB +: `PAD_W] == '0);
  endfunction : is_write

  // =====================================================================
  // serial link
  sensor_pkg::link_state_e state;
  sensor_pkg::link_state_e next_state;
  logic [`CNT_W-1:0] bit_cnt;
  logic [`CNT_W-1:0] next_cnt;
  logic [`CMD_W-1:0] cmd_sr;
  logic [`CMD_W-1:0] next_cmd;
  logic [`DATA_W-1:0] out_sr;
  logic [`DATA_W-1:0] next_out;
  logic sdi_bit;
  logic next_sdi_bit;
  logic next_sdo;
  logic next_oe;

  always_comb begin
    next_state = state;
    next_cnt = bit_cnt;
    next_cmd = cmd_sr;
    next_out = out_sr;
    next_sdi_bit = sdi_bit;
    next_sdo = sdo;
    next_oe = sdo_oe;
    case (state)
      sensor_pkg::st_reload: begin
        next_state = sensor_pkg::st_idle;
      end
      sensor_pkg::st_idle: begin
        // deselected: clock and data ignored, pin released
        next_oe = 1'b0;
        next_sdo = 1'b0;
        if (cs_fall) begin
          next_state = sensor_pkg::st_sel;
          next_out = bus.result;
          next_sdo = bus.result[`DATA_W-1];
          next_oe = 1'b1;
          next_cnt = '0;
          next_cmd = '0;
        end
      end
      sensor_pkg::st_sel: begin
        if (cs_rise) begin
          next_state = sensor_pkg::st_idle;
          next_oe = 1'b0;
          next_sdo = 1'b0;
        end else begin
          if (sck_rise) begin
            next_sdi_bit = sdi_s2;
            // only the first frame bits form the command
            if (bit_cnt < `CNT_W'(`CMD_W)) begin
              next_cmd = {cmd_sr[`CMD_W-2:0], sdi_s2};
            end
            // saturates so long chained frames stay legal
            if (bit_cnt != '1) begin
              next_cnt = bit_cnt + `CNT_W'(1);
            end
          end
          if (sck_fall) begin
            // after the word, input bits pass down the chain
            next_out = {out_sr[`DATA_W-2:0], sdi_bit};
            next_sdo = out_sr[`DATA_W-2];
          end
        end
      end
      default: begin
        next_state = sensor_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= sensor_pkg::st_reload;
      bit_cnt <= '0;
      cmd_sr <= '0;
      out_sr <= '0;
      sdi_bit <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_cnt;
      cmd_sr <= next_cmd;
      out_sr <= next_out;
      sdi_bit <= next_sdi_bit;
      sdo <= next_sdo;
      sdo_oe <= next_oe;
    end
  end

  // =====================================================================
  // settings and programming
  logic pend;
  logic next_pend;
  logic [`OTP_W-1:0] pend_bits;
  logic [`OTP_W-1:0] next_pend_bits;
  logic [`FILT_W-1:0] next_filter;
  logic [`TRIM_W-1:0] next_trim;
  logic next_strobe;

  always_comb begin
    next_filter = filter_code;
    next_trim = trim_code;
    next_pend = pend;
    next_pend_bits = pend_bits;
    next_strobe = 1'b0;
    if (state == sensor_pkg::st_reload) begin
      next_filter = bus.otp_bits[`OTP_A_LSB +: `FILT_W];
      next_trim = bus.otp_bits[`OTP_B_LSB +: `TRIM_W];
    end
    // strobe fires in the frame after the one that asked for it,
    // whatever that frame carries
    if (state == sensor_pkg::st_idle && cs_fall && pend) begin
      next_strobe = 1'b1;
      next_pend = 1'b0;
    end
    // a read frame starts with a zero and fails the marker check
    if (state == sensor_pkg::st_sel && cs_rise &&
        is_write(cmd_sr, bit_cnt)) begin
      next_filter = cmd_sr[`A_LSB +: `FILT_W];
      next_trim = cmd_sr[`B_LSB +: `TRIM_W];
      if (cmd_sr[`PROG_BIT]) begin
        next_pend = 1'b1;
        next_pend_bits = {cmd_sr[`A_LSB +: `FILT_W],
                          cmd_sr[`B_LSB +: `TRIM_W]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filter_code <= '0;
      trim_code <= '0;
      pend <= 1'b0;
      pend_bits <= '0;
      otp_prog_strobe <= 1'b0;
    end else begin
      filter_code <= next_filter;
      trim_code <= next_trim;
      pend <= next_pend;
      pend_bits <= next_pend_bits;
      otp_prog_strobe <= next_strobe;
    end
  end

  // =====================================================================
  // gain trim: deviation from mid scale scaled by 1 + (code-32)/128
  logic [`DATA_W-1:0] sample;
  logic [`DATA_W-1:0] next_sample;
  logic sample_valid;
  logic next_valid;
  logic signed [13:0] dev;
  logic signed [6:0] toff;
  logic signed [20:0] prod;
  logic signed [14:0] adj;

  always_comb begin
    dev = $signed({2'b00, adc_data}) - $signed({2'b00, `MID_SCALE});
    toff = $signed({1'b0, trim_code}) - `TRIM_MID;
    prod = dev * toff;
    adj = $signed({dev[13], dev}) + 15'(prod >>> `TRIM_SHIFT) +
          $signed({3'b000, `MID_SCALE});
    next_sample = sample;
    next_valid = adc_valid;
    if (adc_valid) begin
      // clip rather than wrap at the rails
      if (adj < 15'sd0) begin
        next_sample = '0;
      end else if (adj > $signed({3'b000, `FULL_SCALE})) begin
        next_sample = `FULL_SCALE;
      end else begin
        next_sample = adj[`DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample <= '0;
      sample_valid <= 1'b0;
    end else begin
      sample <= next_sample;
      sample_valid <= next_valid;
    end
  end

  // =====================================================================
  // submodules
  assign bus.sample = sample;
  assign bus.sample_valid = sample_valid;
  assign bus.code = filter_code;
  assign bus.prog = otp_prog_strobe;
  assign bus.prog_bits = pend_bits;
  assign otp_fields = bus.otp_bits;

  ewma_filter #(
    .DATA_W(`DATA_W),
    .FRAC_W(`FRAC_W)
  ) u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .f(bus.flt)
  );

  otp_store u_otp (
    .clk(clk),
    .otp_blank(otp_blank),
    .m(bus.mem)
  );

endmodule : hall_sensor_serial_filter_otp

// File: sim/sensor_asserts.sv
`timescale 1ns/10ps
`include "sensor_cfg.svh"

// =====================================================================
// port checks
module sensor_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  // status
  input wire logic otp_blank,
  input wire logic [`FILT_W-1:0] filter_code,
  input wire logic [`TRIM_W-1:0] trim_code,
  input wire logic otp_prog_strobe,
  input wire logic [`OTP_W-1:0] otp_fields
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_oe_select: assert property ($fell(cs_n) |-> ##4 sdo_oe)
    else $error("sdo not driven after select");
  a_oe_release: assert property ($rose(cs_n) |-> ##4 !sdo_oe)
    else $error("sdo still driven after deselect");
  a_sdo_quiet: assert property (!sdo_oe |-> !sdo)
    else $error("sdo active while released");
  // shift only follows a falling edge, so mid-high it must hold
  a_sdo_hold: assert property (sck [*4] |-> $stable(sdo))
    else $error("sdo moved while sck high");
  a_prog_window: assert property (otp_prog_strobe |->
    !cs_n && !$past(cs_n, 2) && ($past(cs_n, 5) || $past(cs_n, 6)))
    else $error("program strobe away from select fall");
  a_fuse_sticky: assert property (!$past(otp_blank) |->
    (($past(otp_fields) & ~otp_fields) == 9'h000))
    else $error("fuse bit cleared");
  a_fuse_cause: assert property ($changed(otp_fields) &&
    !$past(otp_blank) |-> $past(otp_prog_strobe))
    else $error("fuses changed without strobe");
  a_codes_reload: assert property ($rose(rst_n) |-> ##3
    filter_code == otp_fields[8:6] && trim_code == otp_fields[5:0])
    else $error("codes not reloaded from fuses");
endmodule : sensor_asserts

bind hall_sensor_serial_filter_otp sensor_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .sdo(sdo),
  .sdo_oe(sdo_oe), .otp_blank(otp_blank), .filter_code(filter_code),
  .trim_code(trim_code), .otp_prog_strobe(otp_prog_strobe),
  .otp_fields(otp_fields)
);

// File: sim/spi_master.sv
`timescale 1ns/10ps

// =====================================================================
// link master
module spi_master (
  // clock
  input wire logic clk,
  // link pins
  output logic cs_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  task automatic wait_n(input int k);
    repeat (k) @(negedge clk);
  endtask : wait_n

  // 4 clk per half period gives 160 ns; sck idles low between frames
  task automatic frame(input logic [31:0] tx, input int n,
    output logic [31:0] rx);
    rx = 32'h0;
    wait_n(1);
    cs_n = 1'b0;
    wait_n(6);
    for (int i = 0; i < n; i++) begin
      sdi = tx[31-i];
      wait_n(4);
      sck = 1'b1;
      wait_n(4);
      // taken before the fall, an undriven pin reads as unknown
      rx[31-i] = sdo_oe ? sdo : 1'bx;
      sck = 1'b0;
    end
    wait_n(6);
    cs_n = 1'b1;
    sdi = ~sdi;
    wait_n(8);
  endtask : frame
endmodule : spi_master

// File: sim/tb.sv
`timescale 1ns/10ps
`include "sensor_cfg.svh"

module tb;
  // =====================================================================
  // pins and counters
  logic clk, rst_n, cs_n, sck, sdi, sdo, sdo_oe, adc_valid, otp_blank;
  logic otp_prog_strobe;
  logic [`DATA_W-1:0] adc_data;
  logic [`FILT_W-1:0] filter_code;
  logic [`TRIM_W-1:0] trim_code;
  logic [`OTP_W-1:0] otp_fields;
  logic [31:0] rx;
  int error_cnt, n_tests;
  int n_prog;

  hall_sensor_serial_filter_otp dut (.clk(clk), .rst_n(rst_n),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .adc_data(adc_data), .adc_valid(adc_valid), .otp_blank(otp_blank),
    .filter_code(filter_code), .trim_code(trim_code),
    .otp_prog_strobe(otp_prog_strobe), .otp_fields(otp_fields));
  spi_master m (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // counted off the launch edge; one count per one-cycle strobe
  always @(negedge clk) begin
    if (otp_prog_strobe === 1'b1) begin
      n_prog++;
    end
  end

  // =====================================================================
  // helpers
  task automatic check(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [31:0] cmd(input logic [2:0] a,
    input logic [5:0] b, input logic prog);
    return {2'b10, a, b, 4'h0, prog, 16'h0};
  endfunction : cmd

  task automatic wr(input logic [31:0] c);
    m.frame(c, 16, rx);
  endtask : wr

  task automatic rd(input logic [11:0] e);
    m.frame(32'h0, 12, rx);
    check("result", 16'(e), 16'(rx[31:20]));
  endtask : rd

  task automatic feed(input logic [11:0] x);
    adc_data = x;
    adc_valid = 1'b1;
    @(negedge clk);
    adc_valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask : feed

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    otp_blank = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset

  // =====================================================================
  // scenarios
  task automatic t_power();
    check("filter", 16'h0, 16'(filter_code));
    check("drive", 16'h0, 16'(sdo_oe));
    wr(cmd(3'h7, 6'h20, 1'b0));
    feed(12'h800);
    rd(12'h010);
    $display("power test done");
  endtask : t_power

  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      wr(cmd(3'h0, 6'h20, 1'b0));
      feed(12'h000);
      wr(cmd(3'(c), 6'h20, 1'b0));
      feed(12'h800);
      rd(12'h800 >> c);
    end
    $display("codes test done");
  endtask : t_codes

  task automatic t_step();
    logic [11:0] steps [5] = '{12'h9c4, 12'habe, 12'hb3b, 12'hb79,
      12'hb98};
    wr(cmd(3'h0, 6'h20, 1'b0));
    feed(12'h7d0);
    wr(cmd(3'h1, 6'h20, 1'b0));
    foreach (steps[i]) begin
      feed(12'hbb8);
      rd(steps[i]);
    end
    $display("step test done");
  endtask : t_step

  task automatic t_trim();
    wr(cmd(3'h0, 6'h00, 1'b0));
    feed(12'hc00);
    rd(12'hb00);
    wr(cmd(3'h0, 6'h3f, 1'b0));
    feed(12'hc00);
    rd(12'hcf8);
    $display("trim test done");
  endtask : t_trim

  task automatic t_prog();
    wr(cmd(3'h2, 6'h10, 1'b0));
    check("filter", 16'h2, 16'(filter_code));
    check("fuse", 16'h0, 16'(otp_fields));
    wr(cmd(3'h0, 6'h0c, 1'b1));
    check("fuse", 16'h0, 16'(otp_fields));
    m.frame(cmd(3'h0, 6'h0c, 1'b0), 32, rx);
    check("chain", 16'h8180, rx[19:4]);
    check("fuse", 16'h00c, 16'(otp_fields));
    check("strobes", 16'h1, 16'(n_prog));
    wr(cmd(3'h6, 6'h00, 1'b0) | {2'b11, 30'h0});
    check("filter", 16'h0, 16'(filter_code));
    wr(cmd(3'h5, 6'h00, 1'b0));
    check("filter", 16'h5, 16'(filter_code));
    wr(cmd(3'h3, 6'h00, 1'b1));
    wr(cmd(3'h0, 6'h00, 1'b0));
    check("fuse", 16'h0cc, 16'(otp_fields));
    check("strobes", 16'h2, 16'(n_prog));
    do_reset();
    check("trim", 16'h00c, 16'(trim_code));
    check("filter", 16'h3, 16'(filter_code));
    $display("program test done");
  endtask : t_prog

  // =====================================================================
  // verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  initial begin
    rst_n = 1'b0;
    adc_data = 12'h000;
    adc_valid = 1'b0;
    otp_blank = 1'b1;
    error_cnt = 0;
    n_tests = 0;
    do_reset();
    t_power();
    t_codes();
    t_step();
    t_trim();
    t_prog();
    close_out();
  end

  // about five times the expected run
  initial begin
    #600000;
    error_cnt++;
    $display("watchdog expired");
    close_out();
  end
endmodule : tb
